// >>> verilog/ebhi_pkg.sv
// package: constants and types for the external bus hold interface
package ebhi_pkg;
   // =====================================
   // cycle structure
   localparam int unsigned EBHI_OSC_PER_CL = 3;
   localparam int unsigned EBHI_CL_PER_MC_SHORT = 3;
   localparam int unsigned EBHI_CL_PER_MC_LONG = 4;
   localparam int unsigned EBHI_MC_PER_INSN_MIN = 1;
   localparam int unsigned EBHI_MC_PER_INSN_MAX = 19;
   // =====================================
   // memory map
   localparam logic [15:0] EBHI_EXT_LIMIT_56K = 16'hdfff;
   localparam logic [15:0] EBHI_EXT_LIMIT_64K = 16'hffff;
   // =====================================
   // reset values and mode codes
   localparam logic [7:0] EBHI_RST_DATA = 8'h00;
   localparam logic [15:0] EBHI_RST_ADDR = 16'h0000;
   localparam logic [1:0] EBHI_MODE_NONE = 2'h0;
   localparam logic [1:0] EBHI_MODE_EXT_FULL = 2'h1;
   localparam logic [1:0] EBHI_MODE_EXT_56K = 2'h3;

   typedef enum logic [2:0] {
      EBHI_IDLE, EBHI_ADDR, EBHI_STROBE, EBHI_FINISH, EBHI_HOLD
   } ebhi_state_type;
endpackage : ebhi_pkg

// >>> verilog/ebhi_tick_if.sv
// interface: cycle timing strobes between timer and bus controller
`timescale 1ns/1ps
`default_nettype none
interface ebhi_tick_if;
   logic cl_tick;
   logic [2:0] cl_index;
   logic long_cycle;
   logic mc_start;
   logic mc_last;
   modport source (output cl_tick, output cl_index, output mc_start, output mc_last,
                   input long_cycle);
   modport sink (input cl_tick, input cl_index, input mc_start, input mc_last,
                 output long_cycle);
endinterface : ebhi_tick_if
`default_nettype wire

// >>> verilog/ebhi_timer.sv
// module: internal clock cycle and machine cycle timing
`timescale 1ns/1ps
`default_nettype none
module ebhi_timer (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   ebhi_tick_if.source tick
);
   import ebhi_pkg::*;
   logic [1:0] osc_cnt;
   logic [1:0] next_osc_cnt;
   logic [2:0] cl_cnt;
   logic [2:0] next_cl_cnt;
   logic [2:0] cl_end;

   // =====================================
   // divider
   always_comb begin
      cl_end = tick.long_cycle ? 3'(EBHI_CL_PER_MC_LONG - 1) : 3'(EBHI_CL_PER_MC_SHORT - 1);
      next_osc_cnt = osc_cnt;
      next_cl_cnt = cl_cnt;
      if (osc_cnt == 2'(EBHI_OSC_PER_CL - 1)) begin
         next_osc_cnt = 2'h0;
         next_cl_cnt = (cl_cnt >= cl_end) ? 3'h0 : cl_cnt + 3'h1;
      end else begin
         next_osc_cnt = osc_cnt + 2'h1;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         osc_cnt <= 2'h0;
         cl_cnt <= 3'h0;
      end else if (clk_en) begin
         osc_cnt <= next_osc_cnt;
         cl_cnt <= next_cl_cnt;
      end
   end

   assign tick.cl_tick = clk_en && (osc_cnt == 2'(EBHI_OSC_PER_CL - 1));
   assign tick.cl_index = cl_cnt;
   assign tick.mc_start = tick.cl_tick && (cl_cnt >= cl_end);
   assign tick.mc_last = cl_cnt >= cl_end;

   property p_cl_three;
      @(posedge core_clk) disable iff (sys_rst)
         (clk_en && osc_cnt == 2'h0) |-> ##1 (!clk_en || osc_cnt == 2'h1);
   endproperty
   a_cl_three: assert property (p_cl_three)
      else $error("clock cycle divider not stepping by three");
   property p_cnt_range;
      @(posedge core_clk) disable iff (sys_rst)
         (osc_cnt != 2'h3) && (cl_cnt <= 3'h3);
   endproperty
   a_cnt_range: assert property (p_cnt_range)
      else $error("cycle counters out of range");
endmodule : ebhi_timer
`default_nettype wire

// >>> verilog/ebhi_top.sv
// module: external bus hold interface top
`timescale 1ns/1ps
`default_nettype none
module ebhi_top (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic reset_n,
   input wire logic hold_req,
   output logic bus_grant_out,
   input wire logic mode_select_a_in,
   output logic mode_select_a_out,
   output logic mode_select_a_oe,
   input wire logic mode_select_b_in,
   output logic opcode_fetch_marker,
   output logic mode_select_b_oe,
   input wire logic [7:0] data_port_pins_in,
   output logic [7:0] data_port_pins_out,
   output logic [7:0] data_port_pins_oe,
   output logic [7:0] address_port_pins_out,
   output logic [7:0] address_port_pins_oe,
   output logic addr_latch_strobe,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic strobe_oe,
   input wire logic acc_req,
   input wire logic acc_write,
   input wire logic acc_io,
   input wire logic acc_fetch,
   input wire logic [15:0] acc_addr,
   input wire logic [7:0] acc_wdata,
   output logic acc_ready,
   output logic acc_done,
   output logic acc_refused,
   output logic [7:0] acc_rdata,
   input wire logic port_dir_out,
   input wire logic [7:0] port_wdata,
   output logic [7:0] port_rdata,
   output logic [1:0] mem_mode,
   output logic [4:0] insn_mc_count
);
   import ebhi_pkg::*;

   ebhi_tick_if tick ();
   ebhi_timer u_timer (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .tick(tick)
   );

   // =====================================
   // state
   ebhi_state_type state, next_state;
   logic rst_int;
   logic [1:0] mode, next_mode;
   logic mode_taken, next_mode_taken;
   logic wr, next_wr, io, next_io, fetch, next_fetch;
   logic [15:0] addr, next_addr;
   logic [7:0] wdata, next_wdata;
   logic [7:0] d_out, next_d_out, d_oe, next_d_oe;
   logic [7:0] a_out, next_a_out, a_oe, next_a_oe;
   logic ale, next_ale, rd_n, next_rd_n, wr_n, next_wr_n, s_oe, next_s_oe;
   logic grant, next_grant, m_a, next_m_a, m_b, next_m_b, m_oe, next_m_oe;
   logic ready, next_ready, done, next_done, refused, next_refused;
   logic [7:0] rdata, next_rdata, prdata, next_prdata;
   logic [4:0] mc_cnt, next_mc_cnt;
   logic ext_mode, over_limit;

   assign rst_int = !reset_n;
   assign ext_mode = mode != EBHI_MODE_NONE;
   assign over_limit = (mode == EBHI_MODE_EXT_56K) && (acc_addr > EBHI_EXT_LIMIT_56K);
   assign tick.long_cycle = 1'b0;

   // =====================================
   // next values
   always_comb begin
      next_state = state;
      next_mode = mode;
      next_mode_taken = 1'b1;
      next_wr = wr;
      next_io = io;
      next_fetch = fetch;
      next_addr = addr;
      next_wdata = wdata;
      next_ale = 1'b0;
      next_rd_n = 1'b1;
      next_wr_n = 1'b1;
      next_s_oe = ext_mode;
      next_grant = grant;
      next_m_a = io;
      next_m_b = 1'b0;
      next_m_oe = mode_taken;
      next_done = 1'b0;
      next_refused = 1'b0;
      next_ready = 1'b0;
      next_rdata = rdata;
      next_prdata = data_port_pins_in;
      next_mc_cnt = mc_cnt;
      next_d_out = ext_mode ? d_out : port_wdata;
      next_d_oe = ext_mode ? d_oe : {8{port_dir_out}};
      next_a_out = a_out;
      next_a_oe = ext_mode ? 8'hff : 8'h00;
      if (!mode_taken) begin
         next_mode = {mode_select_b_in, mode_select_a_in};
      end
      case (state)
         EBHI_IDLE: begin
            next_ready = ext_mode && !hold_req;
            next_d_oe = ext_mode ? 8'h00 : {8{port_dir_out}};
            if (hold_req && tick.mc_start) begin
               next_state = EBHI_HOLD;
               next_grant = 1'b1;
            end else if (acc_req && ready) begin
               if (over_limit) begin
                  next_refused = 1'b1;
               end else begin
                  next_state = EBHI_ADDR;
                  next_wr = acc_write;
                  next_io = acc_io;
                  next_fetch = acc_fetch;
                  next_addr = acc_addr;
                  next_wdata = acc_wdata;
                  next_mc_cnt = acc_fetch ? 5'h1 : ((mc_cnt == 5'(EBHI_MC_PER_INSN_MAX))
                                ? mc_cnt : mc_cnt + 5'h1);
               end
            end
         end
         EBHI_ADDR: begin
            next_d_out = addr[7:0];
            next_d_oe = 8'hff;
            next_a_out = addr[15:8];
            next_ale = 1'b1;
            next_m_a = io;
            next_m_b = fetch;
            if (tick.cl_tick) begin
               next_state = EBHI_STROBE;
            end
         end
         EBHI_STROBE: begin
            next_m_b = fetch;
            if (wr) begin
               next_d_out = wdata;
               next_d_oe = 8'hff;
               next_wr_n = 1'b0;
            end else begin
               next_d_oe = 8'h00;
               next_rd_n = 1'b0;
               next_rdata = data_port_pins_in;
            end
            if (tick.cl_tick && tick.cl_index == 3'h2) begin
               next_state = EBHI_FINISH;
            end
         end
         EBHI_FINISH: begin
            next_d_oe = 8'h00;
            if (tick.mc_start) begin
               next_state = EBHI_IDLE;
               next_done = 1'b1;
            end
         end
         EBHI_HOLD: begin
            next_s_oe = 1'b0;
            next_d_oe = 8'h00;
            next_a_oe = 8'h00;
            if (!hold_req) begin
               next_state = EBHI_IDLE;
               next_grant = 1'b0;
            end
         end
         default: begin
            next_state = EBHI_IDLE;
         end
      endcase
      if (rst_int) begin
         next_state = EBHI_IDLE;
         next_mode_taken = 1'b0;
         next_d_oe = 8'h00;
         next_a_oe = 8'h00;
         next_ale = 1'b0;
         next_rd_n = 1'b1;
         next_wr_n = 1'b1;
         next_grant = 1'b0;
         next_m_oe = 1'b0;
         next_ready = 1'b0;
         next_done = 1'b0;
         next_refused = 1'b0;
      end
   end

   // =====================================
   // registers
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= EBHI_IDLE;
         mode <= EBHI_MODE_NONE;
         mode_taken <= 1'b0;
         wr <= 1'b0;
         io <= 1'b0;
         fetch <= 1'b0;
         addr <= EBHI_RST_ADDR;
         wdata <= EBHI_RST_DATA;
         d_out <= EBHI_RST_DATA;
         d_oe <= 8'h00;
         a_out <= 8'h00;
         a_oe <= 8'h00;
         ale <= 1'b0;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         s_oe <= 1'b0;
         grant <= 1'b0;
         m_a <= 1'b0;
         m_b <= 1'b0;
         m_oe <= 1'b0;
         ready <= 1'b0;
         done <= 1'b0;
         refused <= 1'b0;
         rdata <= EBHI_RST_DATA;
         prdata <= EBHI_RST_DATA;
         mc_cnt <= 5'h0;
      end else if (clk_en) begin
         state <= next_state;
         mode <= next_mode;
         mode_taken <= next_mode_taken;
         wr <= next_wr;
         io <= next_io;
         fetch <= next_fetch;
         addr <= next_addr;
         wdata <= next_wdata;
         d_out <= next_d_out;
         d_oe <= next_d_oe;
         a_out <= next_a_out;
         a_oe <= next_a_oe;
         ale <= next_ale;
         rd_n <= next_rd_n;
         wr_n <= next_wr_n;
         s_oe <= next_s_oe;
         grant <= next_grant;
         m_a <= next_m_a;
         m_b <= next_m_b;
         m_oe <= next_m_oe;
         ready <= next_ready;
         done <= next_done;
         refused <= next_refused;
         rdata <= next_rdata;
         prdata <= next_prdata;
         mc_cnt <= next_mc_cnt;
      end
   end

   // =====================================
   // outputs
   assign bus_grant_out = grant;
   assign mode_select_a_out = m_a;
   assign mode_select_a_oe = m_oe;
   assign opcode_fetch_marker = m_b;
   assign mode_select_b_oe = m_oe;
   assign data_port_pins_out = d_out;
   assign data_port_pins_oe = d_oe;
   assign address_port_pins_out = a_out;
   assign address_port_pins_oe = a_oe;
   assign addr_latch_strobe = ale;
   assign read_strobe_n = rd_n;
   assign write_strobe_n = wr_n;
   assign strobe_oe = s_oe;
   assign acc_ready = ready;
   assign acc_done = done;
   assign acc_refused = refused;
   assign acc_rdata = rdata;
   assign port_rdata = prdata;
   assign mem_mode = mode;
   assign insn_mc_count = mc_cnt;

   // =====================================
   // checks
   property p_hold_stays;
      @(posedge core_clk) disable iff (sys_rst || rst_int)
         (state == EBHI_HOLD && hold_req) |=> (state == EBHI_HOLD);
   endproperty
   a_hold_stays: assert property (p_hold_stays) else $error("left hold with request high");
   property p_grant_drop;
      @(posedge core_clk) disable iff (sys_rst || rst_int)
         (state == EBHI_HOLD && !hold_req && clk_en) |=> !bus_grant_out;
   endproperty
   a_grant_drop: assert property (p_grant_drop) else $error("grant not released");
   property p_rd_no_drive;
      @(posedge core_clk) disable iff (sys_rst)
         !read_strobe_n |-> (data_port_pins_oe == 8'h00);
   endproperty
   a_rd_no_drive: assert property (p_rd_no_drive) else $error("driving during read");
   property p_rd_reset;
      @(posedge core_clk) disable iff (sys_rst) $past(rst_int && clk_en) |-> read_strobe_n;
   endproperty
   a_rd_reset: assert property (p_rd_reset) else $error("read strobe low in reset");
   property p_wr_data;
      @(posedge core_clk) disable iff (sys_rst)
         !write_strobe_n |-> (data_port_pins_oe == 8'hff && data_port_pins_out == wdata
            && read_strobe_n);
   endproperty
   a_wr_data: assert property (p_wr_data) else $error("write without data");
   property p_ale_addr;
      @(posedge core_clk) disable iff (sys_rst)
         addr_latch_strobe |-> (data_port_pins_oe == 8'hff && data_port_pins_out == addr[7:0]);
   endproperty
   a_ale_addr: assert property (p_ale_addr) else $error("latch strobe without address");
   property p_hold_float;
      @(posedge core_clk) disable iff (sys_rst)
         (bus_grant_out && $past(bus_grant_out)) |-> (!strobe_oe && data_port_pins_oe == 8'h00);
   endproperty
   a_hold_float: assert property (p_hold_float) else $error("bus driven while granted");
   property p_dir_byte;
      @(posedge core_clk) disable iff (sys_rst)
         (data_port_pins_oe == 8'h00) || (data_port_pins_oe == 8'hff);
   endproperty
   a_dir_byte: assert property (p_dir_byte) else $error("data port split direction");
   property p_mc_max;
      @(posedge core_clk) disable iff (sys_rst) insn_mc_count <= 5'(EBHI_MC_PER_INSN_MAX);
   endproperty
   a_mc_max: assert property (p_mc_max) else $error("instruction too long");
endmodule : ebhi_top
`default_nettype wire

// >>> tb/ebhi_ext_mem.sv
// partner: external memory on the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module ebhi_ext_mem (
   input wire logic core_clk,
   input wire logic ale,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [7:0] ad_out,
   input wire logic [7:0] hi_out,
   output logic [7:0] drive,
   output logic [15:0] last_addr
);
   logic [7:0] mem [0:255];
   logic [7:0] last_drive;
   initial begin
      last_addr = 16'h0000;
      last_drive = 8'h00;
      foreach (mem[i]) mem[i] = 8'h00;
   end
   // ==========================
   // address latch and write capture
   always @(posedge core_clk) begin
      if (ale) begin
         last_addr <= {hi_out, ad_out};
      end
      if (!wr_n) begin
         mem[last_addr[7:0]] <= ad_out;
      end
      if (!rd_n) begin
         last_drive <= drive;
      end
   end
   // drive only under read strobe, else move off last value
   assign drive = rd_n ? ~last_drive : mem[last_addr[7:0]];
endmodule : ebhi_ext_mem
`default_nettype wire

// >>> tb/ebhi_top_tb_top.sv
// testbench: external bus hold interface
`timescale 1ns/1ps
`default_nettype none
module ebhi_top_tb_top;
   import ebhi_pkg::*;
   logic core_clk = 0, sys_rst = 1, reset_n = 1, hold_req = 0, clk_en = 1;
   logic ma = 1, mb = 0, acc_req = 0, acc_write = 0, acc_io = 0, acc_fetch = 0;
   logic [15:0] acc_addr = 16'h0000;
   logic [7:0] acc_wdata = 8'h00, port_wdata = 8'h00, ext_in = 8'h00, pin;
   logic port_dir_out = 0;
   logic grant, ma_out, ma_oe, fm_out, mb_oe, ale, rd_n, wr_n, s_oe;
   logic rdy, done, refused;
   logic [7:0] d_out, d_oe, a_out, a_oe, rdata, prd, drv;
   logic [1:0] mem_mode;
   logic [4:0] mc_cnt;
   logic [15:0] l_addr;
   int errors = 0, compares = 0;
   always #50 core_clk = ~core_clk;
   assign pin = (d_oe == 8'hff) ? d_out : (s_oe ? drv : ext_in);
   ebhi_top u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .reset_n(reset_n), .hold_req(hold_req), .bus_grant_out(grant),
      .mode_select_a_in(ma), .mode_select_a_out(ma_out), .mode_select_a_oe(ma_oe),
      .mode_select_b_in(mb), .opcode_fetch_marker(fm_out), .mode_select_b_oe(mb_oe),
      .data_port_pins_in(pin), .data_port_pins_out(d_out), .data_port_pins_oe(d_oe),
      .address_port_pins_out(a_out), .address_port_pins_oe(a_oe),
      .addr_latch_strobe(ale), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
      .strobe_oe(s_oe), .acc_req(acc_req), .acc_write(acc_write), .acc_io(acc_io),
      .acc_fetch(acc_fetch), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
      .acc_ready(rdy), .acc_done(done), .acc_refused(refused), .acc_rdata(rdata),
      .port_dir_out(port_dir_out), .port_wdata(port_wdata), .port_rdata(prd),
      .mem_mode(mem_mode), .insn_mc_count(mc_cnt));
   ebhi_ext_mem u_mem (.core_clk(core_clk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
      .ad_out(d_out), .hi_out(a_out), .drive(drv), .last_addr(l_addr));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      compares++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic close_out();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   // ==========================
   // one access through the internal request port
   task automatic acc(input logic w, io, f, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] rd, output logic rf, fm, iom);
      int n;
      n = 0;
      rf = 0;
      fm = 0;
      iom = 0;
      acc_write <= w;
      acc_io <= io;
      acc_fetch <= f;
      acc_addr <= a;
      acc_wdata <= d;
      acc_req <= 1;
      do begin
         @(posedge core_clk);
         n++;
      end while (rdy !== 1'b1 && n < 100);
      chk("access taken", 16'h1, 16'(rdy));
      acc_req <= 0;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
         if (fm_out === 1'b1) fm = 1;
         if (ma_out === 1'b1) iom = 1;
         if (refused === 1'b1) rf = 1;
      end while (done !== 1'b1 && refused !== 1'b1 && n < 100);
      if (n >= 100) chk("access end", 16'h1, 16'h0);
      @(posedge core_clk);
      rd = rdata;
   endtask : acc
   task automatic reset_pin(input logic [1:0] m);
      reset_n <= 0;
      {mb, ma} <= m;
      repeat (3) @(posedge core_clk);
      chk("rd strobe in reset", 16'h1, 16'(rd_n));
      chk("wr strobe in reset", 16'h1, 16'(wr_n));
      reset_n <= 1;
      repeat (4) @(posedge core_clk);
      chk("mode", 16'(m), 16'(mem_mode));
   endtask : reset_pin
   // ==========================
   // scenarios
   task automatic t_reset();
      chk("rd idle", 16'h1, 16'(rd_n));
      chk("wr idle", 16'h1, 16'(wr_n));
      chk("grant idle", 16'h0, 16'(grant));
      chk("mode oe", 16'h3, 16'({mb_oe, ma_oe}));
      chk("addr oe", 16'hff, 16'(a_oe));
   endtask : t_reset
   task automatic t_rw();
      logic [7:0] r;
      logic rf, fm, iom;
      acc(1, 0, 0, 16'h12a5, 8'h5a, r, rf, fm, iom);
      chk("latched addr", 16'h12a5, l_addr);
      chk("mem indicator", 16'h0, 16'(iom));
      chk("no fetch mark", 16'h0, 16'(fm));
      acc(0, 0, 1, 16'h12a5, 8'h00, r, rf, fm, iom);
      chk("read back", 16'h5a, 16'(r));
      chk("fetch mark", 16'h1, 16'(fm));
      acc(1, 1, 0, 16'h0033, 8'hc3, r, rf, fm, iom);
      chk("io indicator", 16'h1, 16'(iom));
      acc(0, 1, 0, 16'h0033, 8'h00, r, rf, fm, iom);
      chk("io read", 16'hc3, 16'(r));
      chk("cycles since fetch", 16'h3, 16'(mc_cnt));
   endtask : t_rw
   task automatic t_hold();
      int n;
      n = 0;
      hold_req <= 1;
      do @(posedge core_clk); while (grant !== 1'b1 && ++n < 60);
      chk("grant", 16'h1, 16'(grant));
      repeat (12) begin
         @(posedge core_clk);
         chk("grant kept", 16'h1, 16'(grant));
      end
      chk("bus float", 16'h0, {d_oe, a_oe});
      chk("strobe float", 16'h0, 16'(s_oe));
      hold_req <= 0;
      repeat (3) @(posedge core_clk);
      chk("grant off", 16'h0, 16'(grant));
      chk("strobe back", 16'h1, 16'(s_oe));
   endtask : t_hold
   task automatic t_limit();
      logic [7:0] r;
      logic rf, fm, iom;
      reset_pin(EBHI_MODE_EXT_56K);
      acc(0, 0, 0, 16'he000, 8'h00, r, rf, fm, iom);
      chk("over limit", 16'h1, 16'(rf));
      acc(1, 0, 0, 16'hdfff, 8'h96, r, rf, fm, iom);
      chk("top ok", 16'h0, 16'(rf));
      chk("top addr", 16'hdfff, l_addr);
   endtask : t_limit
   task automatic t_port();
      reset_pin(EBHI_MODE_NONE);
      port_dir_out <= 1;
      port_wdata <= 8'ha5;
      repeat (4) @(posedge core_clk);
      chk("port oe out", 16'hff, 16'(d_oe));
      chk("port data", 16'ha5, 16'(d_out));
      port_dir_out <= 0;
      ext_in <= 8'h3c;
      repeat (4) @(posedge core_clk);
      chk("port oe in", 16'h0, 16'(d_oe));
      chk("port read", 16'h3c, 16'(prd));
      clk_en <= 0;
      ext_in <= 8'hc3;
      repeat (4) @(posedge core_clk);
      chk("port read frozen", 16'h3c, 16'(prd));
      clk_en <= 1;
      repeat (2) @(posedge core_clk);
      chk("port read thawed", 16'hc3, 16'(prd));
   endtask : t_port
   initial begin
      #2000000;
      errors++;
      close_out();
   end
   initial begin
      repeat (12) @(posedge core_clk);
      sys_rst <= 0;
      repeat (4) @(posedge core_clk);
      t_reset();
      t_rw();
      t_hold();
      t_limit();
      t_port();
      close_out();
   end
endmodule : ebhi_top_tb_top
`default_nettype wire
